/* verilog/ptcw_params.svh */
// Constants for the pre-trigger capture window block.
`ifndef PTCW_PARAMS_SVH
`define PTCW_PARAMS_SVH

`define PTCW_CLK_PERIOD_PS 8000
`define PTCW_INTERP_RES_PS 200
`define PTCW_INTERP_W 5
`define PTCW_ST_INHIB_BIT 5
`define PTCW_ST_BLOCK_BIT 6
`define PTCW_FIELD_W 16
`define PTCW_DATA_W 32
`define PTCW_WORD_W 80
`define PTCW_STAT_BYTES 4'h2
`define PTCW_NORM_BYTES 4'h4
`define PTCW_FAST_BYTES 4'h2
`define PTCW_TIME_RST 32'h0000_0000
`define PTCW_EVT_RST 32'h0000_0000

`endif

/* verilog/ptcw_pkg.sv */
// Types shared by the pre-trigger capture window block.
`default_nettype none
package ptcw_pkg;
  typedef enum logic [2:0] {
    PTCW_IDLE = 3'h0,
    PTCW_MON = 3'h1,
    PTCW_POST = 3'h3,
    PTCW_RDSET = 3'h2,
    PTCW_RDREQ = 3'h6,
    PTCW_RDLD = 3'h7,
    PTCW_SEND = 3'h5
  } ptcw_state_e;
endpackage
`default_nettype wire

/* verilog/ptcw_mem.sv */
// Capture memory with one write port and a registered read port.
`timescale 1ns/1ps
`default_nettype none
module ptcw_mem #(
  parameter int WIDTH = 80,
  parameter int ADDR_W = 8
) (
  input wire logic i_core_clk,
  input wire logic i_ce,
  input wire logic i_wr_en,
  input wire logic [ADDR_W-1:0] i_wr_addr,
  input wire logic [WIDTH-1:0] i_wr_data,
  input wire logic i_rd_en,
  input wire logic [ADDR_W-1:0] i_rd_addr,
  output logic [WIDTH-1:0] o_rd_data
);
  logic [WIDTH-1:0] mem_ff [0:(1<<ADDR_W)-1];

  always_ff @(posedge i_core_clk) begin
    if (i_ce && i_wr_en) begin
      mem_ff[i_wr_addr] <= i_wr_data;
    end
    if (i_ce && i_rd_en) begin
      o_rd_data <= mem_ff[i_rd_addr];
    end
  end
endmodule
`default_nettype wire

/* verilog/ptcw_top.sv */
// Pre-trigger acquisition, capture memory and binary byte output.
//
// Contract
// - While monitoring, every sample goes to memory and nothing is output.
// - On pre-trigger, window placed about it, samples read back and output.
// - Window spans at least one block: N measurements plus arming sample; the code caps it at the 256-sample memory depth.
// - Early pre-trigger outputs all samples collected, even short of a block.
// - Pre-trigger mode selects single block or repeated blocks of N.
// - Single block mode satisfies block holdoff only once per acquisition.
// - Multi block repeats: holdoff, enable detector, N measurements, disable.
// - Pre-trigger edges between blocks are not recognised.
// - Status bit 6 is set on every block initiating sample.
// - Block arming sample carries time of the arming condition.
// - Event field of an arming sample is unused; receiver must ignore it.
// - Selected arming modes clear the event counter between blocks.
// - Time and event counters wrap to zero without stopping acquisition.
// - Event data is 32 bits in normal mode, 16 bits in fast mode.
// - Event counter accumulates every trigger event on the input channel.
// - Time interval without expanded data outputs time data only.
// - With inhibit enabled, the inhibit level stops or starts measurement.
// - Interpolator reports event to clock delay as 5 bits, 200 ps steps.
// - Status bit 5 marks a sample preceded by inhibit-discarded samples.
// - Status field is sent most significant byte first.
// - Time counter accumulates system clock cycles and is output unsigned.
`timescale 1ns/1ps
`default_nettype none
`include "ptcw_params.svh"
module ptcw_top #(
  parameter int ADDR_W = 8,
  parameter int N_W = 16
) (
  input wire logic i_core_clk,
  input wire logic i_resetn,
  input wire logic i_ce,
  input wire logic i_start,
  input wire logic i_pretrig_en,
  input wire logic i_multi_block,
  input wire logic [N_W-1:0] i_block_n,
  input wire logic [N_W-1:0] i_pre_len,
  input wire logic i_fast_mode,
  input wire logic i_expanded,
  input wire logic i_time_interval,
  input wire logic i_clr_evt_between,
  input wire logic i_inhibit_en,
  input wire logic i_inhibit,
  input wire logic i_block_arm,
  input wire logic i_trig,
  input wire logic [`PTCW_INTERP_W-1:0] i_fine_delay,
  input wire logic i_pretrig,
  input wire logic i_ready,
  output logic [7:0] o_data,
  output logic o_valid,
  output logic o_sample_start,
  output logic o_done,
  output logic o_busy,
  output logic o_detect_en
);
  localparam int DEPTH = 1 << ADDR_W;
  localparam int CW = ADDR_W + 1;
  localparam logic [CW-1:0] DEPTH_C = CW'(DEPTH);

  ptcw_pkg::ptcw_state_e state_ff, nxt_state;
  logic [`PTCW_DATA_W-1:0] time_ff, nxt_time;
  logic [`PTCW_DATA_W-1:0] evt_ff, nxt_evt;
  logic blk_active_ff, nxt_blk_active;
  logic armed_once_ff, nxt_armed_once;
  logic [N_W-1:0] meas_cnt_ff, nxt_meas_cnt;
  logic lost_ff, nxt_lost;
  logic pre_prev_ff, nxt_pre_prev;
  logic [ADDR_W-1:0] wr_ptr_ff, nxt_wr_ptr;
  logic [CW-1:0] stored_ff, nxt_stored;
  logic [N_W:0] post_left_ff, nxt_post_left;
  logic [ADDR_W-1:0] rd_ptr_ff, nxt_rd_ptr;
  logic [CW-1:0] out_left_ff, nxt_out_left;
  logic [`PTCW_WORD_W-1:0] sr_ff, nxt_sr;
  logic [3:0] byte_left_ff, nxt_byte_left;
  logic first_ff, nxt_first;
  logic done_ff, nxt_done;

  logic acq, inhib_act, arm_take, meas_take, discard, pre_edge;
  logic wr_en, rd_en, evt_out;
  logic [`PTCW_FIELD_W-1:0] status;
  logic [`PTCW_WORD_W-1:0] wr_word, rd_word;
  logic [N_W:0] win, win_cap, pre_cap;
  logic [CW-1:0] n_out;
  logic [3:0] fld_bytes, smp_bytes;

  // Even count of 100 ps steps, so bit 0 is always zero.
  function automatic logic [`PTCW_INTERP_W-1:0] interp_code(
    input logic [`PTCW_INTERP_W-1:0] fine
  );
    interp_code = {fine[`PTCW_INTERP_W-1:1], 1'b0};
  endfunction

  function automatic logic [`PTCW_FIELD_W-1:0] make_status(
    input logic blk, input logic inh, input logic [`PTCW_INTERP_W-1:0] fine
  );
    logic [`PTCW_FIELD_W-1:0] s;
    s = '0;
    s[`PTCW_ST_BLOCK_BIT] = blk;
    s[`PTCW_ST_INHIB_BIT] = inh;
    s[`PTCW_INTERP_W-1:0] = interp_code(fine);
    make_status = s;
  endfunction

  assign acq = (state_ff == ptcw_pkg::PTCW_MON) ||
               (state_ff == ptcw_pkg::PTCW_POST);
  assign inhib_act = i_inhibit_en && i_inhibit;
  // Arming is never held off by inhibit.
  assign arm_take = acq && !blk_active_ff && i_block_arm &&
                    (i_multi_block || !armed_once_ff);
  assign meas_take = acq && blk_active_ff && i_trig && !inhib_act;
  assign discard = acq && blk_active_ff && i_trig && inhib_act;
  assign wr_en = arm_take || meas_take;
  // The detector only looks while a block is running.
  assign o_detect_en = (state_ff == ptcw_pkg::PTCW_MON) && i_pretrig_en &&
                       blk_active_ff;
  assign pre_edge = o_detect_en && i_pretrig && !pre_prev_ff;

  // The event field of an arming sample is left zero and carries no meaning.
  assign status = make_status(arm_take, meas_take && lost_ff,
                              i_fine_delay);
  assign wr_word = arm_take ? {status, time_ff, `PTCW_EVT_RST} :
                   {status, time_ff, evt_ff};

  assign win = {1'b0, i_block_n} + {{N_W{1'b0}}, 1'b1};
  assign win_cap = (win > (N_W+1)'(DEPTH)) ? (N_W+1)'(DEPTH) : win;
  assign pre_cap = ({1'b0, i_pre_len} > win_cap) ? win_cap :
                   {1'b0, i_pre_len};
  assign n_out = ((N_W+1)'(stored_ff) < win_cap) ? stored_ff :
                 CW'(win_cap);
  assign fld_bytes = i_fast_mode ? `PTCW_FAST_BYTES :
                     `PTCW_NORM_BYTES;
  assign evt_out = i_expanded || !i_time_interval;
  assign smp_bytes = `PTCW_STAT_BYTES + fld_bytes +
                     (evt_out ? fld_bytes : 4'h0);
  assign rd_en = (state_ff == ptcw_pkg::PTCW_RDREQ);

  ptcw_mem #(
    .WIDTH(`PTCW_WORD_W),
    .ADDR_W(ADDR_W)
  ) u_mem (
    .i_core_clk(i_core_clk),
    .i_ce(i_ce),
    .i_wr_en(wr_en),
    .i_wr_addr(wr_ptr_ff),
    .i_wr_data(wr_word),
    .i_rd_en(rd_en),
    .i_rd_addr(rd_ptr_ff),
    .o_rd_data(rd_word)
  );

  // Counters run from reset, the event count cleared on arming when selected; a wrap is left to the data consumer.
  always_comb begin
    nxt_time = time_ff + 32'h0000_0001;
    nxt_evt = evt_ff;
    if (arm_take && i_clr_evt_between) begin
      nxt_evt = `PTCW_EVT_RST;
    end
    if (i_trig) begin
      nxt_evt = nxt_evt + 32'h0000_0001;
    end
  end

  always_comb begin
    nxt_state = state_ff;
    nxt_blk_active = blk_active_ff;
    nxt_armed_once = armed_once_ff;
    nxt_meas_cnt = meas_cnt_ff;
    nxt_lost = discard || (lost_ff && !meas_take);
    nxt_pre_prev = i_pretrig;
    nxt_wr_ptr = wr_ptr_ff;
    nxt_stored = stored_ff;
    nxt_post_left = post_left_ff;
    nxt_rd_ptr = rd_ptr_ff;
    nxt_out_left = out_left_ff;
    nxt_sr = sr_ff;
    nxt_byte_left = byte_left_ff;
    nxt_first = first_ff;
    nxt_done = 1'b0;
    if (wr_en) begin
      nxt_wr_ptr = wr_ptr_ff + ADDR_W'(1);
      if (stored_ff != DEPTH_C) begin
        nxt_stored = stored_ff + CW'(1);
      end
    end
    if (arm_take) begin
      nxt_blk_active = 1'b1;
      nxt_armed_once = 1'b1;
      nxt_meas_cnt = '0;
    end else if (meas_take) begin
      nxt_meas_cnt = meas_cnt_ff + N_W'(1);
      // A multi block run closes the block and the detector after N.
      if (i_multi_block && (nxt_meas_cnt >= i_block_n)) begin
        nxt_blk_active = 1'b0;
      end
    end
    case (state_ff)
      ptcw_pkg::PTCW_IDLE: begin
        nxt_blk_active = 1'b0;
        nxt_lost = 1'b0;
        if (i_start) begin
          nxt_state = ptcw_pkg::PTCW_MON;
          nxt_armed_once = 1'b0;
          nxt_wr_ptr = '0;
          nxt_stored = '0;
        end
      end
      ptcw_pkg::PTCW_MON: begin
        if (pre_edge) begin
          nxt_post_left = win_cap - pre_cap;
          nxt_state = (win_cap == pre_cap) ? ptcw_pkg::PTCW_RDSET :
                      ptcw_pkg::PTCW_POST;
        end
      end
      ptcw_pkg::PTCW_POST: begin
        if (wr_en) begin
          nxt_post_left = post_left_ff - (N_W+1)'(1);
          if (post_left_ff == (N_W+1)'(1)) begin
            nxt_state = ptcw_pkg::PTCW_RDSET;
          end
        end
      end
      ptcw_pkg::PTCW_RDSET: begin
        nxt_blk_active = 1'b0;
        nxt_rd_ptr = wr_ptr_ff - n_out[ADDR_W-1:0];
        nxt_out_left = n_out;
        if (n_out == '0) begin
          nxt_state = ptcw_pkg::PTCW_IDLE;
          nxt_done = 1'b1;
        end else begin
          nxt_state = ptcw_pkg::PTCW_RDREQ;
        end
      end
      ptcw_pkg::PTCW_RDREQ: begin
        nxt_state = ptcw_pkg::PTCW_RDLD;
      end
      ptcw_pkg::PTCW_RDLD: begin
        // Status first, then time, then event, each high byte first.
        if (i_fast_mode) begin
          nxt_sr = {rd_word[79:64], rd_word[47:32], rd_word[15:0],
                    32'h0000_0000};
        end else begin
          nxt_sr = rd_word;
        end
        nxt_byte_left = smp_bytes;
        nxt_first = 1'b1;
        nxt_state = ptcw_pkg::PTCW_SEND;
      end
      ptcw_pkg::PTCW_SEND: begin
        if (i_ready) begin
          nxt_sr = {sr_ff[`PTCW_WORD_W-9:0], 8'h00};
          nxt_byte_left = byte_left_ff - 4'h1;
          nxt_first = 1'b0;
          if (byte_left_ff == 4'h1) begin
            nxt_rd_ptr = rd_ptr_ff + ADDR_W'(1);
            nxt_out_left = out_left_ff - CW'(1);
            if (out_left_ff == CW'(1)) begin
              nxt_state = ptcw_pkg::PTCW_IDLE;
              nxt_done = 1'b1;
            end else begin
              nxt_state = ptcw_pkg::PTCW_RDREQ;
            end
          end
        end
      end
      default: begin
        nxt_state = ptcw_pkg::PTCW_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_resetn) begin
      state_ff <= ptcw_pkg::PTCW_IDLE;
      time_ff <= `PTCW_TIME_RST;
      evt_ff <= `PTCW_EVT_RST;
      blk_active_ff <= 1'b0;
      armed_once_ff <= 1'b0;
      meas_cnt_ff <= '0;
      lost_ff <= 1'b0;
      pre_prev_ff <= 1'b0;
      wr_ptr_ff <= '0;
      stored_ff <= '0;
      post_left_ff <= '0;
      rd_ptr_ff <= '0;
      out_left_ff <= '0;
      sr_ff <= '0;
      byte_left_ff <= 4'h0;
      first_ff <= 1'b0;
      done_ff <= 1'b0;
    end else if (i_ce) begin
      state_ff <= nxt_state;
      time_ff <= nxt_time;
      evt_ff <= nxt_evt;
      blk_active_ff <= nxt_blk_active;
      armed_once_ff <= nxt_armed_once;
      meas_cnt_ff <= nxt_meas_cnt;
      lost_ff <= nxt_lost;
      pre_prev_ff <= nxt_pre_prev;
      wr_ptr_ff <= nxt_wr_ptr;
      stored_ff <= nxt_stored;
      post_left_ff <= nxt_post_left;
      rd_ptr_ff <= nxt_rd_ptr;
      out_left_ff <= nxt_out_left;
      sr_ff <= nxt_sr;
      byte_left_ff <= nxt_byte_left;
      first_ff <= nxt_first;
      done_ff <= nxt_done;
    end
  end

  // Output only ever appears after detection, never while monitoring.
  assign o_valid = (state_ff == ptcw_pkg::PTCW_SEND);
  assign o_data = sr_ff[`PTCW_WORD_W-1:`PTCW_WORD_W-8];
  assign o_sample_start = o_valid && first_ff;
  assign o_done = done_ff;
  assign o_busy = (state_ff != ptcw_pkg::PTCW_IDLE);
endmodule
`default_nettype wire

/* bench/ptcw_sva.sv */
// Assertion checker for the pre-trigger capture window block.
`timescale 1ns/1ps
`default_nettype none
module ptcw_sva (
  input wire logic i_core_clk,
  input wire logic i_resetn,
  input wire logic i_ce,
  input wire logic i_start,
  input wire logic i_ready,
  input wire logic [7:0] o_data,
  input wire logic o_valid,
  input wire logic o_sample_start,
  input wire logic o_done,
  input wire logic o_busy,
  input wire logic o_detect_en
);
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_resetn);
  sequence byte_held;
    i_ce && o_valid && !i_ready;
  endsequence
  sequence byte_taken;
    i_ce && o_sample_start && i_ready;
  endsequence
  sequence idle_start;
    i_ce && i_start && !o_busy;
  endsequence
  mon_silent_a: assert property (o_detect_en |-> !o_valid)
    else $error("byte shown while monitoring");
  byte_hold_a: assert property (byte_held |=> o_valid && $stable(o_data))
    else $error("byte dropped before acceptance");
  first_status_a: assert property ($rose(o_valid) |-> o_sample_start)
    else $error("sample did not open with status");
  done_pulse_a: assert property (o_done |-> !o_valid ##1 !o_done)
    else $error("done not a lone pulse");
  start_busy_a: assert property (idle_start |=> o_busy)
    else $error("start not taken");
  detect_busy_a: assert property (o_detect_en |-> o_busy)
    else $error("detector on while idle");
  idle_quiet_a: assert property (!o_busy |-> !o_valid && !o_detect_en)
    else $error("output while idle");
  end_done_a: assert property ($fell(o_busy) |-> ##[0:1] o_done)
    else $error("readout ended without done");
  start_once_a: assert property (byte_taken |=> !o_sample_start)
    else $error("sample start held past first byte");
  done_idle_a: assert property (o_done |-> !o_busy)
    else $error("done while still busy");
endmodule
bind ptcw_top ptcw_sva u_sva (
  .i_core_clk(i_core_clk),
  .i_resetn(i_resetn),
  .i_ce(i_ce),
  .i_start(i_start),
  .i_ready(i_ready),
  .o_data(o_data),
  .o_valid(o_valid),
  .o_sample_start(o_sample_start),
  .o_done(o_done),
  .o_busy(o_busy),
  .o_detect_en(o_detect_en)
);
`default_nettype wire

/* bench/ptcw_host.sv */
// Host model that takes bytes from the binary output with random stalls.
`timescale 1ns/1ps
`default_nettype none
module ptcw_host (
  input wire logic i_core_clk,
  input wire logic i_valid,
  input wire logic [7:0] i_data,
  output logic o_ready,
  output logic o_take,
  output logic [7:0] o_byte
);
  int seed = 82;
  initial begin
    {o_ready, o_take, o_byte} = 10'h000;
  end
  // Stalls often, so that held bytes are really exercised.
  always @(posedge i_core_clk) begin
    o_take <= i_valid && o_ready;
    o_byte <= i_data;
    o_ready <= ($random(seed) & 3) != 0;
  end
endmodule
`default_nettype wire

/* bench/ptcw_top_test.sv */
// Self-checking bench for the pre-trigger capture window block.
`timescale 1ns/1ps
`default_nettype none
module ptcw_top_test;
  logic i_core_clk, i_resetn, i_ce, i_start, i_pretrig_en, i_multi_block;
  logic i_fast_mode, i_expanded, i_time_interval, i_clr_evt_between;
  logic i_inhibit_en, i_inhibit, i_block_arm, i_trig, i_pretrig, i_ready;
  logic [15:0] i_block_n, i_pre_len;
  logic [4:0] i_fine_delay;
  logic [7:0] o_data, h_byte;
  logic o_valid, o_sample_start, o_done, o_busy, o_detect_en, h_take;
  logic [31:0] tc, ev;
  logic lost;
  logic [72:0] smp[$];
  logic [8:0] exp_q[$];
  int bad_count = 0, samples_checked = 0, seed = 82;
  ptcw_top uut (.i_core_clk(i_core_clk), .i_resetn(i_resetn), .i_ce(i_ce),
    .i_start(i_start), .i_pretrig_en(i_pretrig_en),
    .i_multi_block(i_multi_block), .i_block_n(i_block_n),
    .i_pre_len(i_pre_len), .i_fast_mode(i_fast_mode),
    .i_expanded(i_expanded), .i_time_interval(i_time_interval),
    .i_clr_evt_between(i_clr_evt_between), .i_inhibit_en(i_inhibit_en),
    .i_inhibit(i_inhibit), .i_block_arm(i_block_arm), .i_trig(i_trig),
    .i_fine_delay(i_fine_delay), .i_pretrig(i_pretrig), .i_ready(i_ready),
    .o_data(o_data), .o_valid(o_valid), .o_sample_start(o_sample_start),
    .o_done(o_done), .o_busy(o_busy), .o_detect_en(o_detect_en));
  ptcw_host host (.i_core_clk(i_core_clk), .i_valid(o_valid),
    .i_data(o_data), .o_ready(i_ready), .o_take(h_take), .o_byte(h_byte));
  initial begin
    i_core_clk = 1'b0;
    forever #4 i_core_clk = ~i_core_clk;
  end
  // Free running time count, as the device keeps it.
  always @(posedge i_core_clk) tc <= i_resetn ? tc + 32'h1 : 32'h0;
  task automatic check(input logic [7:0] seen, input logic [7:0] want);
    samples_checked++;
    if (seen !== want) begin
      bad_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask
  task automatic close_out();
    if (bad_count == 0 && samples_checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // Bytes of an arming sample's event field carry bit 8 and are skipped.
  always @(posedge i_core_clk) begin
    if (h_take && exp_q.size() == 0)
      check({7'h00, h_take}, 8'h00);
    else if (h_take) begin
      if (!exp_q[0][8]) check(h_byte, exp_q[0][7:0]);
      void'(exp_q.pop_front());
    end
  end
  // Mode bits of md: multi, fast, time interval, expanded, clear.
  task automatic run(input logic [4:0] md, input int n, input int pre,
                     input string ops);
    int w, j, m, f, na;
    logic [4:0] fd;
    logic [72:0] s;
    na = 0;
    {i_multi_block, i_fast_mode, i_time_interval, i_expanded,
      i_clr_evt_between} <= md;
    i_block_n <= 16'(n);
    i_pre_len <= 16'(pre);
    i_start <= 1'b1;
    smp.delete();
    @(posedge i_core_clk);
    i_start <= 1'b0;
    @(posedge i_core_clk);
    for (int k = 0; k < ops.len(); k++) begin
      fd = 5'($unsigned($random(seed)) % 19);
      i_fine_delay <= fd;
      i_block_arm <= ops[k] == "a";
      i_trig <= ops[k] == "t" || ops[k] == "i";
      i_inhibit <= ops[k] == "i";
      i_pretrig <= ops[k] == "g" || ops[k] == "p";
      @(posedge i_core_clk);
      // Single block mode takes only the first arm of an acquisition.
      if (ops[k] == "a" && (md[4] || na == 0)) begin
        na++;
        if (md[0]) ev = 32'h0;
        smp.push_back({4'hA, fd[4:1], 1'b0, tc, ev});
      end else if (ops[k] == "i") begin
        ev++;
        lost = 1'b1;
      end else if (ops[k] == "t") begin
        smp.push_back({3'h0, lost, fd[4:1], 1'b0, tc, ev});
        ev++;
        lost = 1'b0;
      end
      {i_block_arm, i_trig, i_inhibit, i_pretrig} <= 4'h0;
      repeat (2) @(posedge i_core_clk);
    end
    // Once the post count is met the window holds the newest samples.
    w = n + 1 > 256 ? 256 : n + 1;
    f = md[3] ? 2 : 4;
    for (j = smp.size() > w ? smp.size() - w : 0; j < smp.size(); j++) begin
      s = smp[j];
      exp_q.push_back(9'h000);
      exp_q.push_back({1'b0, s[71:64]});
      for (m = f - 1; m >= 0; m--) exp_q.push_back({1'b0, s[32+8*m +: 8]});
      for (m = f - 1; m >= 0 && (md[1] || !md[2]); m--)
        exp_q.push_back({s[72], s[8*m +: 8]});
    end
    for (j = 0; j < 3000 && o_done !== 1'b1; j++) @(posedge i_core_clk);
    if (o_done !== 1'b1) begin
      bad_count++;
      close_out();
    end
    // The last taken byte reaches the comparer one edge later.
    @(posedge i_core_clk);
    check(8'(exp_q.size()), 8'h00);
  endtask
  initial begin
    {i_ce, i_pretrig_en, i_inhibit_en} = 3'h7;
    {i_resetn, i_start, i_multi_block, i_fast_mode, i_expanded} = 5'h00;
    {i_time_interval, i_clr_evt_between, i_inhibit, i_block_arm} = 4'h0;
    {i_trig, i_pretrig, i_block_n, i_pre_len, i_fine_delay} = 39'h0;
    {ev, lost} = 33'h0;
    repeat (6) @(posedge i_core_clk);
    i_resetn <= 1'b1;
    run(5'h02, 4, 2, "atitpttt");
    run(5'h0C, 3, 4, "attatttp");
    run(5'h11, 2, 3, "attgatp");
    run(5'h1E, 2, 3, "atp");
    close_out();
  end
endmodule
`default_nettype wire
